// ---- design/wait_gen_pkg.sv ----
// Package for the bus wait-state generator: states, cycle groups, timing.
// Assumes a single processor clock domain with synchronous inputs.
package wait_gen_pkg;

	// Sequencer states, Gray code along the count path
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_RELEASE = 3'h1,
		ST_EXT2    = 3'h3,
		ST_EXT3    = 3'h2,
		ST_EXT4    = 3'h6,
		ST_EXT5    = 3'h7,
		ST_EXT6    = 3'h5,
		ST_EXT7    = 3'h4
	} wait_state_e;

	localparam logic [2:0] WAIT_MAX      = 3'h7;
	localparam logic [2:0] WAIT_NONE     = 3'h0;
	localparam logic [2:0] WAIT_ROM      = 3'h1;
	localparam logic [2:0] WAIT_SERIAL   = 3'h2;
	localparam logic [2:0] WAIT_HIGH_GAP = 3'h1;
	localparam logic [2:0] WAIT_LOW_GAP  = 3'h0;

	// Upper address page bounds
	localparam logic [7:0] PAGE_ROM_LOW   = 8'h00;
	localparam logic [7:0] PAGE_ROM_MON   = 8'h1d;
	localparam logic [7:0] PAGE_SERIAL    = 8'h1e;
	localparam logic [7:0] PAGE_WIDE_LO   = 8'h20;
	localparam logic [7:0] PAGE_WIDE_HI   = 8'h5f;
	localparam logic [7:0] PAGE_NARROW_LO = 8'h60;
	localparam logic [7:0] PAGE_NARROW_HI = 8'h7f;
	localparam logic [7:0] PAGE_GAP_LO    = 8'h80;
	localparam logic [7:0] PAGE_GAP_HI    = 8'hbf;

	// Bus cycle inputs that travel together
	typedef struct packed {
		logic       stretched_latch_strobe;
		logic       hold_grant_n;
		logic [7:0] upper_address_bits;
	} bus_cycle_s;

endpackage

// ---- design/wait_map.sv ----
// Address-to-wait-count map for the upper address byte.
// Assumes the byte is already latched and stable through the cycle.
`timescale 1ns/1ps
`default_nettype none
module wait_map (
	// Address
	input  wire logic [7:0] i_page,
	// Wait count
	output logic      [2:0] o_waits
);
	import wait_gen_pkg::*;

	always_comb begin
		o_waits = WAIT_LOW_GAP;
		if (i_page == PAGE_ROM_LOW || i_page == PAGE_ROM_MON) begin
			o_waits = WAIT_ROM;
		end else if (i_page == PAGE_SERIAL) begin
			o_waits = WAIT_SERIAL;
		end else if (i_page >= PAGE_WIDE_LO && i_page <= PAGE_NARROW_HI) begin
			o_waits = WAIT_NONE;
		end else if (i_page >= PAGE_GAP_LO && i_page <= PAGE_GAP_HI) begin
			o_waits = WAIT_HIGH_GAP;
		end
	end
endmodule
`default_nettype wire

// ---- design/stall_retime.sv ----
// Falling-edge re-timing flop for the stall request.
// Assumes the same processor clock as the sequencer, sampled on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module stall_retime (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	// Stall request, active low
	input  wire logic i_stall_req_n,
	// Re-timed request, active low
	output logic      o_stall_q_n
);
	always_ff @(negedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_stall_q_n <= 1'b1;
		end else begin
			o_stall_q_n <= i_stall_req_n;
		end
	end
endmodule
`default_nettype wire

// ---- design/bus_wait_state_generator.sv ----
// Wait-state generator for the external bus of a 16-bit controller.
// Assumes i_sys_clk is the processor clock output and inputs are synchronous.
//
// How it works
// - Three-bit sequencer steps only on rising edges of the processor clock.
// - Idle bus keeps the sequencer in state 0.
// - Leave idle on strobe, no hold grant, and a region needing waits.
// - Decode uses the stretched strobe, held past the next rising edge.
// - In idle, stall request follows the address decode combinationally.
// - With waits needed, leave idle at the next rising edge.
// - One wait goes straight to release; release drops the stall request.
// - n waits walk extend states 2..n asserted, then release; seven maximum.
// - Falling-edge flop re-times stall request to drive processor ready.
// - Registered stall also asserts while strobe high and request asserted.
// - After strobe falls, stall holds until request drops and a falling edge.
// - Expansion bus stall input also asserts the registered stall.
// - Fixed map: rom 1, serial 2, memories 0, upper gap 1, others 0.
// - Inputs: upper address byte, clock, hold grant, reset, stretched strobe, expansion stall.
`timescale 1ns/1ps
`default_nettype none
module bus_wait_state_generator (
	// Processor clock output and reset
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst_n,
	// Bus cycle from the processor
	input  wire wait_gen_pkg::bus_cycle_s i_bus,
	// Expansion bus stall, active high
	input  wire logic                    i_expansion_stall_in,
	// Stall outputs, active low
	output logic                         o_stall_req_n,
	output logic                         o_stall_registered_n,
	// Sequencer state for observation
	output logic                   [2:0] o_state
);
	import wait_gen_pkg::*;

	wait_state_e state_q;
	wait_state_e state_d;
	logic [2:0]  waits;
	logic        need_wait;
	logic        cycle_go;
	logic        stall_flop_n;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	wait_map u_map (
		.i_page  (i_bus.upper_address_bits),
		.o_waits (waits)
	);

	function automatic wait_state_e first_state(input logic [2:0] n);
		first_state = (n == 3'h1) ? ST_RELEASE : ST_EXT2;
	endfunction

	function automatic logic [2:0] ext_index(input wait_state_e s);
		case (s)
			ST_EXT2: ext_index = 3'h2;
			ST_EXT3: ext_index = 3'h3;
			ST_EXT4: ext_index = 3'h4;
			ST_EXT5: ext_index = 3'h5;
			ST_EXT6: ext_index = 3'h6;
			ST_EXT7: ext_index = 3'h7;
			default: ext_index = 3'h0;
		endcase
	endfunction

	function automatic wait_state_e ext_next(input wait_state_e s);
		case (s)
			ST_EXT2: ext_next = ST_EXT3;
			ST_EXT3: ext_next = ST_EXT4;
			ST_EXT4: ext_next = ST_EXT5;
			ST_EXT5: ext_next = ST_EXT6;
			ST_EXT6: ext_next = ST_EXT7;
			default: ext_next = ST_RELEASE;
		endcase
	endfunction

	assign need_wait = (waits != WAIT_NONE);
	assign cycle_go  = i_bus.stretched_latch_strobe && i_bus.hold_grant_n
		&& need_wait;

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cycle_go) begin
					state_d = first_state(waits);
				end
			end
			ST_RELEASE: begin
				state_d = ST_IDLE;
			end
			ST_EXT2, ST_EXT3, ST_EXT4, ST_EXT5, ST_EXT6, ST_EXT7: begin
				if (ext_index(state_q) >= waits || state_q == ST_EXT7) begin
					state_d = ST_RELEASE;
				end else begin
					state_d = ext_next(state_q);
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stall request and re-timed stall

	always_comb begin
		o_stall_req_n = 1'b1;
		if (!i_rst_n) begin
			o_stall_req_n = 1'b1;
		end else begin
			case (state_q)
				ST_IDLE:    o_stall_req_n = !(cycle_go);
				ST_RELEASE: o_stall_req_n = 1'b1;
				default:    o_stall_req_n = 1'b0;
			endcase
		end
	end

	stall_retime u_retime (
		.i_sys_clk     (i_sys_clk),
		.i_rst_n       (i_rst_n),
		.i_stall_req_n (o_stall_req_n),
		.o_stall_q_n   (stall_flop_n)
	);

	assign o_stall_registered_n = stall_flop_n
		&& !(i_bus.stretched_latch_strobe && !o_stall_req_n)
		&& !i_expansion_stall_in;

	assign o_state = state_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	idle_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && !cycle_go) |=> state_q == ST_IDLE)
		else $error("sequencer left idle without a wait cycle");

	leave_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && cycle_go) |=> state_q != ST_IDLE)
		else $error("sequencer did not leave idle");

	one_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && cycle_go && waits == WAIT_ROM)
		|=> state_q == ST_RELEASE ##1 state_q == ST_IDLE)
		else $error("one-wait cycle path wrong");

	two_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && cycle_go && waits == WAIT_SERIAL)
		|=> !o_stall_req_n ##1 state_q == ST_RELEASE ##1 state_q == ST_IDLE)
		else $error("two-wait cycle path wrong");

	release_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_q == ST_RELEASE |-> o_stall_req_n)
		else $error("stall request asserted in release");

	idle_decode_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && !cycle_go) |-> o_stall_req_n)
		else $error("stall request without decode");

	bounded_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_q != ST_IDLE |-> ##[1:7] state_q == ST_IDLE)
		else $error("wait sequence exceeded seven states");

	flop_follow_a: assert property (@(negedge i_sys_clk) disable iff (!i_rst_n)
		!o_stall_req_n |=> !o_stall_registered_n)
		else $error("registered stall did not follow request");

	strobe_stall_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_bus.stretched_latch_strobe && !o_stall_req_n) |-> !o_stall_registered_n)
		else $error("registered stall missing while strobe high");

	expansion_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_expansion_stall_in |-> !o_stall_registered_n)
		else $error("expansion stall not passed through");

	// Reset is watched without a disable so the forced values are seen
	reset_quiet_a: assert property (@(posedge i_sys_clk)
		!i_rst_n |-> (o_stall_req_n && state_q == ST_IDLE))
		else $error("stall request or state active in reset");

	hold_block_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && !i_bus.hold_grant_n) |=> state_q == ST_IDLE)
		else $error("sequencer started while bus granted away");

	hold_no_stall_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && !i_bus.hold_grant_n) |-> o_stall_req_n)
		else $error("stall request while bus granted away");

	release_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_q == ST_RELEASE |=> state_q == ST_IDLE)
		else $error("release did not return to idle");

	extend_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q != ST_IDLE && state_q != ST_RELEASE) |-> !o_stall_req_n)
		else $error("stall request dropped in an extend state");

	idle_stall_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && cycle_go) |-> !o_stall_req_n)
		else $error("stall request missing for a wait region");

	retime_drop_a: assert property (@(negedge i_sys_clk) disable iff (!i_rst_n)
		o_stall_req_n |=> stall_flop_n)
		else $error("re-timed stall held after request dropped");

	zero_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_q == ST_IDLE && waits == WAIT_NONE) |=> state_q == ST_IDLE)
		else $error("zero-wait region started the sequencer");

	one_wait_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_q == ST_IDLE ##1 state_q == ST_RELEASE ##1 state_q == ST_IDLE);
	serial_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_q == ST_EXT2 ##1 state_q == ST_RELEASE);
	expansion_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_expansion_stall_in && state_q == ST_IDLE);
	hold_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		state_q == ST_IDLE && !i_bus.hold_grant_n && need_wait
		&& i_bus.stretched_latch_strobe);

endmodule
`default_nettype wire

// ---- bench/cpu_bus_model.sv ----
// Processor bus model: drives the latched page, hold grant and stretched strobe.
// Assumes the registered stall drives ready, looked at just after each falling edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
	// Processor clock and ready
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_stall_registered_n,
	// Bus cycle to the generator
	output var  wait_gen_pkg::bus_cycle_s  o_bus
);
	import wait_gen_pkg::*;

	logic [4:0] waits_seen;
	event       cycle_done;

	initial o_bus = '{1'b0, 1'b1, 8'h60};
	initial waits_seen = 5'h00;

	////////////////////////////////////////////////////////////////////////////
	task automatic run_cycle(input logic [7:0] page, input logic grant_n);
		@(posedge i_sys_clk);
		o_bus <= '{1'b1, grant_n, page};
		fork
			// Strobe stays high past the rising edge that takes the request
			@(posedge i_sys_clk) o_bus.stretched_latch_strobe <= 1'b0;
		join_none
		if (grant_n) begin
			waits_seen = 5'h00;
			@(negedge i_sys_clk);
			#1;
			while (!i_stall_registered_n && waits_seen < 5'h10) begin
				waits_seen = waits_seen + 5'h01;
				@(negedge i_sys_clk);
				#1;
			end
			-> cycle_done;
		end else begin
			@(posedge i_sys_clk);
		end
		@(posedge i_sys_clk);
		// Latched page moves to a region with no waits between cycles
		o_bus <= '{1'b0, 1'b1, 8'h60};
	endtask
endmodule
`default_nettype wire

// ---- bench/tb_bus_wait_state_generator.sv ----
// Self-checking testbench for the bus wait-state generator.
// Assumes the package, design files and processor bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_bus_wait_state_generator;
	import wait_gen_pkg::*;

	logic       sys_clk     = 1'b0;
	logic       rst_n       = 1'b0;
	logic       exp_stall   = 1'b0;
	logic       req_n;
	logic       reg_n;
	logic [2:0] state;
	bus_cycle_s bus;
	logic [4:0] notes[$];
	logic [4:0] want;
	int         fails       = 0;
	int         comparisons = 0;
	int         cycles      = 0;
	logic [7:0] pages[14]   = '{8'h00, 8'h01, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20,
		8'h5f, 8'h60, 8'h7f, 8'h80, 8'hbf, 8'hc0, 8'hff};

	always #50 sys_clk = ~sys_clk;

	bus_wait_state_generator dut (
		.i_sys_clk            (sys_clk),
		.i_rst_n              (rst_n),
		.i_bus                (bus),
		.i_expansion_stall_in (exp_stall),
		.o_stall_req_n        (req_n),
		.o_stall_registered_n (reg_n),
		.o_state              (state)
	);

	cpu_bus_model cpu (
		.i_sys_clk            (sys_clk),
		.i_stall_registered_n (reg_n),
		.o_bus                (bus)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [4:0] map_waits(input logic [7:0] p);
		if (p == 8'h00 || p == 8'h1d || (p >= 8'h80 && p <= 8'hbf)) return 5'h01;
		if (p == 8'h1e) return 5'h02;
		return 5'h00;
	endfunction

	task automatic close_out();
		if (fails == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// One processor cycle, with the expansion agent stalling for ext clocks
	task automatic bus_op(input logic [7:0] page, input int ext);
		logic [4:0] w;
		w = map_waits(page);
		if (ext > w) w = 5'(ext);
		notes.push_back(w);
		fork
			cpu.run_cycle(page, 1'b1);
			if (ext > 0) begin
				@(posedge sys_clk) exp_stall <= 1'b1;
				repeat (ext) @(posedge sys_clk);
				exp_stall <= 1'b0;
			end
		join
	endtask

	////////////////////////////////////////////////////////////////////////////
	always begin
		@(cpu.cycle_done);
		want = (notes.size() > 0) ? notes.pop_front() : 5'h1f;
		`CHK("waits", want, cpu.waits_seen)
		@(posedge sys_clk);
		#1;
		`CHK("state after release", ST_IDLE, state)
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		void'($urandom(85368));
		repeat (6) @(posedge sys_clk);
		`CHK("stall in reset", 1'b1, req_n)
		`CHK("state in reset", ST_IDLE, state)
		rst_n <= 1'b1;
		foreach (pages[i]) bus_op(pages[i], 0);
		bus_op(8'h60, 3);
		bus_op(8'h1e, 3);
		bus_op(8'h00, 1);
		// Hold granted away: a page needing waits must not start the sequencer
		cpu.run_cycle(8'h1e, 1'b0);
		#1;
		`CHK("state under hold", ST_IDLE, state)
		repeat (40) begin
			repeat ($urandom_range(2, 0)) @(posedge sys_clk);
			bus_op(8'($urandom_range(255, 0)),
				($urandom_range(3, 0) == 0) ? int'($urandom_range(4, 1)) : 0);
		end
		repeat (4) @(posedge sys_clk);
		`CHK("notes left", 0, notes.size())
		close_out();
	end
endmodule
`default_nettype wire
